// ==== adcc_pkg.sv ====
/*
 * Shared constants and carriers for the converter control block: register
 * indices, field layouts, reset values, channel codes, timing counts and the
 * sequencer state encoding.
 * Assumes an 8-bit register port with a 2-bit register index.
 */
package adcc_pkg;

    // Register indices on the plain register port
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_RES_HIGH = 2'h1;
    localparam logic [1:0] ADDR_RES_LOW = 2'h2;
    localparam logic [1:0] ADDR_GAIN = 2'h3;

    localparam int RESULT_BITS = 10;
    localparam int CHANNELS = 16;

    // Conversion control register, bit 7 down to bit 0
    typedef struct packed {
        logic [3:0] channel_code;
        logic diff_mode_sel;
        logic mux_out_sel;
        logic clk_div_sel;
        logic conv_busy;
    } adcc_ctrl_type;

    // Gain control register, bit 7 down to bit 0
    typedef struct packed {
        logic standalone_amp_en;
        logic temp_sense_en;
        logic trim_cfg;
        logic [1:0] reserved;
        logic [2:0] amp_factor_code;
    } adcc_gain_type;

    localparam adcc_ctrl_type CTRL_RESET = 8'h00;
    localparam adcc_gain_type GAIN_RESET = 8'h00;
    localparam logic [1:0] GAIN_RSV_ZERO = 2'h0;
    localparam logic [2:0] GAIN_BYPASS = 3'h0;

    // Low result register: two result bits on top, the rest read as zero
    localparam logic [5:0] RES_LOW_PAD = 6'h00;
    localparam int RES_LOW_KEEP = 2;

    // Channel codes
    localparam logic [3:0] CH_TEMP = 4'h7;
    localparam logic [3:0] CH_FIRST_EXT = 4'ha;
    localparam logic [3:0] CH_LAST_MUX_DIFF = 4'hb;
    localparam logic [3:0] CH_ROUTE_OUT = 4'he;
    localparam logic [3:0] CH_PAIR_FLIP = 4'h1;

    // Prescaler: divide by 1 or by 16
    localparam logic [3:0] DIV16_LAST = 4'hf;
    localparam logic [3:0] DIV_START = 4'h0;

    // Sample window in converter clocks, then one clock per result bit
    localparam logic [1:0] SAMPLE_LAST = 2'h2;
    localparam logic [1:0] SAMPLE_START = 2'h0;
    localparam logic [RESULT_BITS-1:0] SAR_FIRST_BIT = 10'h200;
    localparam logic [RESULT_BITS-1:0] SAR_ZERO = 10'h000;

    // Gray-coded sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b11
    } adcc_state_type;

endpackage

// ==== adcc_control.sv ====
/*
 * Control logic of a multiplexed 10-bit successive-approximation converter:
 * control, result and gain registers, prescaler, conversion sequencer,
 * channel gating and amplifier configuration.
 * Assumes a register master on clk, and an analog comparator whose decision
 * for the driven trial code is valid on comp_in by each converter clock.
 */
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps

module adcc_control (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic comp_in,
    output logic conv_clk_en,
    output logic sample_en,
    output logic [adcc_pkg::RESULT_BITS-1:0] dac_trial,
    output logic conv_done,
    output logic [adcc_pkg::CHANNELS-1:0] chan_plus_sel,
    output logic [adcc_pkg::CHANNELS-1:0] chan_minus_sel,
    output logic route_out_pin_en,
    output logic conv_input_pin_en,
    output logic amp_enable,
    output logic amp_open_loop,
    output logic [2:0] amp_factor_code,
    output logic standalone_amp_en,
    output logic temp_sense_en
);

    adcc_pkg::adcc_ctrl_type ctrl_r;
    adcc_pkg::adcc_ctrl_type cfg_r;
    adcc_pkg::adcc_ctrl_type wr_ctrl;
    adcc_pkg::adcc_gain_type gain_r;
    adcc_pkg::adcc_state_type state_r;
    logic [adcc_pkg::RESULT_BITS-1:0] result_r;
    logic [adcc_pkg::RESULT_BITS-1:0] trial_r;
    logic [adcc_pkg::RESULT_BITS-1:0] mask_r;
    logic [adcc_pkg::RESULT_BITS-1:0] keep;
    logic [3:0] div_r;
    logic [1:0] sample_cnt_r;
    logic [7:0] rdata_r;
    logic done_r;
    logic ctrl_wr;
    logic start;
    logic abort;
    logic tick;
    logic finish;
    logic gate_en;
    logic plus_valid;
    logic minus_valid;
    logic [3:0] minus_code;

    assign wr_ctrl = reg_wdata;
    assign ctrl_wr = reg_wr && reg_addr == adcc_pkg::ADDR_CTRL;
    assign start = ctrl_wr && wr_ctrl.conv_busy;
    assign abort = ctrl_wr && !wr_ctrl.conv_busy;

    // Prescaler runs only while a conversion is active
    assign tick = ctrl_r.conv_busy && (!cfg_r.clk_div_sel || div_r == adcc_pkg::DIV16_LAST);
    assign finish = tick && state_r == adcc_pkg::ST_CONVERT && mask_r[0];
    assign keep = comp_in ? trial_r : (trial_r & ~mask_r);

    // Control register; a software write wins over the hardware clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= adcc_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_r <= wr_ctrl;
        end else if (finish) begin
            ctrl_r.conv_busy <= 1'b0;
        end
    end

    // Settings used by the running conversion, captured at start
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= adcc_pkg::CTRL_RESET;
        end else if (start) begin
            cfg_r <= wr_ctrl;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gain_r <= adcc_pkg::GAIN_RESET;
        end else if (reg_wr && reg_addr == adcc_pkg::ADDR_GAIN) begin
            gain_r <= {reg_wdata[7:5], adcc_pkg::GAIN_RSV_ZERO, reg_wdata[2:0]};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_r <= adcc_pkg::DIV_START;
        end else if (start || !ctrl_r.conv_busy) begin
            div_r <= adcc_pkg::DIV_START;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end

    // Sequencer: sample window, then one decision per result bit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= adcc_pkg::ST_IDLE;
        end else if (start) begin
            state_r <= adcc_pkg::ST_SAMPLE;
        end else if (abort) begin
            state_r <= adcc_pkg::ST_IDLE;
        end else if (tick) begin
            case (state_r)
                adcc_pkg::ST_SAMPLE: begin
                    if (sample_cnt_r == adcc_pkg::SAMPLE_LAST) begin
                        state_r <= adcc_pkg::ST_CONVERT;
                    end
                end
                adcc_pkg::ST_CONVERT: begin
                    if (mask_r[0]) begin
                        state_r <= adcc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= adcc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sample_cnt_r <= adcc_pkg::SAMPLE_START;
        end else if (start) begin
            sample_cnt_r <= adcc_pkg::SAMPLE_START;
        end else if (tick && state_r == adcc_pkg::ST_SAMPLE) begin
            sample_cnt_r <= sample_cnt_r + 2'h1;
        end
    end

    // Successive approximation: trial code and the bit under test
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trial_r <= adcc_pkg::SAR_ZERO;
            mask_r <= adcc_pkg::SAR_ZERO;
        end else if (start) begin
            trial_r <= adcc_pkg::SAR_FIRST_BIT;
            mask_r <= adcc_pkg::SAR_FIRST_BIT;
        end else if (tick && state_r == adcc_pkg::ST_CONVERT) begin
            trial_r <= keep | (mask_r >> 1);
            mask_r <= mask_r >> 1;
        end
    end

    // Result: hardware completion wins over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (finish) begin
            result_r <= keep;
        end else if (reg_wr && reg_addr == adcc_pkg::ADDR_RES_HIGH) begin
            result_r[9:2] <= reg_wdata;
        end else if (reg_wr && reg_addr == adcc_pkg::ADDR_RES_LOW) begin
            result_r[1:0] <= reg_wdata[7:6];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= finish;
        end
    end

    // Read data stands in the cycle after the read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                adcc_pkg::ADDR_CTRL: rdata_r <= ctrl_r;
                adcc_pkg::ADDR_RES_HIGH: rdata_r <= result_r[9:2];
                adcc_pkg::ADDR_RES_LOW: rdata_r <= {result_r[1:0], adcc_pkg::RES_LOW_PAD};
                adcc_pkg::ADDR_GAIN: rdata_r <= gain_r;
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    // Amplifier: trim forces open loop, differential forces bypass unless trim is set
    assign amp_enable = gain_r.trim_cfg
        || (gain_r.amp_factor_code != adcc_pkg::GAIN_BYPASS && !ctrl_r.diff_mode_sel);
    assign amp_open_loop = gain_r.trim_cfg;
    assign amp_factor_code = gain_r.amp_factor_code;
    assign standalone_amp_en = gain_r.standalone_amp_en;
    assign temp_sense_en = gain_r.temp_sense_en;

    // Channel decode from the live control register so paths settle early
    always_comb begin
        plus_valid = 1'b0;
        if (ctrl_r.channel_code == adcc_pkg::CH_TEMP) begin
            plus_valid = !ctrl_r.diff_mode_sel && !ctrl_r.mux_out_sel && gain_r.temp_sense_en;
        end else if (ctrl_r.channel_code >= adcc_pkg::CH_FIRST_EXT) begin
            if (!ctrl_r.mux_out_sel) begin
                plus_valid = 1'b1;
            end else if (ctrl_r.diff_mode_sel) begin
                plus_valid = ctrl_r.channel_code <= adcc_pkg::CH_LAST_MUX_DIFF;
            end else begin
                plus_valid = ctrl_r.channel_code < adcc_pkg::CH_ROUTE_OUT;
            end
        end
    end

    assign minus_valid = plus_valid && ctrl_r.diff_mode_sel && ctrl_r.channel_code >= adcc_pkg::CH_FIRST_EXT;
    assign minus_code = ctrl_r.channel_code ^ adcc_pkg::CH_PAIR_FLIP;
    assign gate_en = ctrl_r.conv_busy || ctrl_r.mux_out_sel || amp_enable;

    genvar ch;
    generate
        for (ch = 0; ch < adcc_pkg::CHANNELS; ch = ch + 1) begin : g_chan
            assign chan_plus_sel[ch] = gate_en && plus_valid && ctrl_r.channel_code == 4'(ch);
            assign chan_minus_sel[ch] = gate_en && minus_valid && minus_code == 4'(ch);
        end
    endgenerate

    assign route_out_pin_en = ctrl_r.mux_out_sel;
    assign conv_input_pin_en = ctrl_r.mux_out_sel;
    assign conv_clk_en = tick;
    assign sample_en = ctrl_r.conv_busy && state_r == adcc_pkg::ST_SAMPLE;
    assign dac_trial = trial_r;
    assign conv_done = done_r;
    assign reg_rdata = rdata_r;

    a_idle_clock_off: assert property (@(posedge clk) disable iff (!resetn)
        !ctrl_r.conv_busy |-> !conv_clk_en)
        else $error("converter clock runs while not busy");

    a_div1_rate: assert property (@(posedge clk) disable iff (!resetn)
        (ctrl_r.conv_busy && !cfg_r.clk_div_sel) |-> conv_clk_en)
        else $error("divide by 1 missed a converter clock");

    a_div16_gap: assert property (@(posedge clk) disable iff (!resetn)
        (conv_clk_en && cfg_r.clk_div_sel && !start) |-> ##1 (!conv_clk_en || !cfg_r.clk_div_sel) [*8])
        else $error("divide by 16 clock came too early");

    a_start_capture: assert property (@(posedge clk) disable iff (!resetn)
        start |=> (ctrl_r.conv_busy && state_r == adcc_pkg::ST_SAMPLE && cfg_r == $past(reg_wdata)))
        else $error("start did not capture control values");

    a_done_result: assert property (@(posedge clk) disable iff (!resetn)
        (finish && !reg_wr) |=> (!ctrl_r.conv_busy && result_r == $past(keep) && conv_done))
        else $error("completion did not clear busy with result");

    a_abort_stop: assert property (@(posedge clk) disable iff (!resetn)
        abort |=> (!ctrl_r.conv_busy && state_r == adcc_pkg::ST_IDLE && !conv_clk_en && !sample_en))
        else $error("abort did not stop the conversion");

    a_mux_reserved: assert property (@(posedge clk) disable iff (!resetn)
        (ctrl_r.mux_out_sel && (ctrl_r.channel_code >= adcc_pkg::CH_ROUTE_OUT
            || ctrl_r.channel_code[3:1] == 3'h4)) |-> chan_plus_sel == '0)
        else $error("reserved mux channel selected an input");

    a_idle_gating: assert property (@(posedge clk) disable iff (!resetn)
        (!ctrl_r.conv_busy && !ctrl_r.mux_out_sel && !amp_enable) |-> (chan_plus_sel == '0 && chan_minus_sel == '0))
        else $error("idle inputs not gated off");

    a_low_zero_read: assert property (@(posedge clk) disable iff (!resetn)
        (reg_rd && reg_addr == adcc_pkg::ADDR_RES_LOW) |=> reg_rdata[5:0] == adcc_pkg::RES_LOW_PAD)
        else $error("low result padding not zero");

    a_high_read: assert property (@(posedge clk) disable iff (!resetn)
        (reg_rd && reg_addr == adcc_pkg::ADDR_RES_HIGH) |=> reg_rdata == $past(result_r[9:2]))
        else $error("high result read wrong");

    a_diff_bypass: assert property (@(posedge clk) disable iff (!resetn)
        (ctrl_r.diff_mode_sel && !gain_r.trim_cfg) |-> !amp_enable)
        else $error("amplifier enabled in differential mode");

    a_trim_open: assert property (@(posedge clk) disable iff (!resetn)
        gain_r.trim_cfg |-> (amp_enable && amp_open_loop))
        else $error("trim did not enable open loop amplifier");

    a_conv_length: assert property (@(posedge clk) disable iff (!resetn)
        (start && !wr_ctrl.clk_div_sel) ##1 (!reg_wr) [*8] ##1 (!reg_wr) [*4] |-> ##[1:2] conv_done)
        else $error("conversion length wrong");

    c_conversion_done: cover property (@(posedge clk) disable iff (!resetn) conv_done);
    c_abort_restart: cover property (@(posedge clk) disable iff (!resetn)
        (ctrl_r.conv_busy && abort) ##1 start);
    c_mux_start: cover property (@(posedge clk) disable iff (!resetn) start && wr_ctrl.mux_out_sel);
    c_div16_done: cover property (@(posedge clk) disable iff (!resetn) finish && cfg_r.clk_div_sel);

endmodule // adcc_control

// ==== adc_control_and_gain_select_tb_top.sv ====
/*
 * Self-checking bench for the converter control block: register access,
 * gain decoding, input gating, conversion timing, abort and result layout.
 * Assumes adcc_pkg and adcc_control are compiled first; comp_in is modelled
 * as an ideal comparator against a bench-held input level.
 */
`timescale 1ns/100ps
module adc_control_and_gain_select_tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, rdv;
    logic [9:0] vin = 10'h000;
    logic [9:0] dac_trial;
    logic comp_in, conv_clk_en, sample_en, conv_done;
    logic [15:0] chan_plus_sel, chan_minus_sel;
    logic route_out_pin_en, conv_input_pin_en, amp_enable, amp_open_loop;
    logic [2:0] amp_factor_code;
    logic standalone_amp_en, temp_sense_en;
    int errors = 0;
    int comparisons = 0;
    int n, p;

    // Ideal comparator: high while the input is at or above the trial code
    assign comp_in = (vin >= dac_trial);

    adcc_control dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_in(comp_in),
        .conv_clk_en(conv_clk_en), .sample_en(sample_en), .dac_trial(dac_trial),
        .conv_done(conv_done), .chan_plus_sel(chan_plus_sel), .chan_minus_sel(chan_minus_sel),
        .route_out_pin_en(route_out_pin_en), .conv_input_pin_en(conv_input_pin_en),
        .amp_enable(amp_enable), .amp_open_loop(amp_open_loop), .amp_factor_code(amp_factor_code),
        .standalone_amp_en(standalone_amp_en), .temp_sense_en(temp_sense_en));

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask

    // Writes the control byte and follows the conversion until done
    task automatic run(input logic [7:0] c, output int cyc, output int pul);
        reg_addr <= adcc_pkg::ADDR_CTRL;
        reg_wdata <= c;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        cyc = 1;
        pul = 0;
        repeat (400) begin
            #1;
            if (conv_done === 1'b1) break;
            if (conv_clk_en === 1'b1) pul++;
            @(posedge clk);
            cyc++;
        end
        // Realign the next request to a rising edge
        @(posedge clk);
    endtask

    task automatic t_reset_vals;
        rd(adcc_pkg::ADDR_CTRL, rdv);
        chk("ctrl reset", 16'h0000, {8'h00, rdv});
        rd(adcc_pkg::ADDR_GAIN, rdv);
        chk("gain reset", 16'h0000, {8'h00, rdv});
        chk("idle clock", 16'h0000, {15'h0, conv_clk_en});
        chk("idle gating", 16'h0000, chan_plus_sel);
    endtask

    task automatic t_gain;
        wr(adcc_pkg::ADDR_GAIN, 8'hff);
        rd(adcc_pkg::ADDR_GAIN, rdv);
        chk("gain reserved", 16'h00e7, {8'h00, rdv});
        chk("trim enable", 16'h0003, {14'h0, amp_enable, amp_open_loop});
        chk("amp enables", 16'h0003, {14'h0, standalone_amp_en, temp_sense_en});
        for (int i = 0; i < 8; i++) begin
            wr(adcc_pkg::ADDR_GAIN, {5'h00, i[2:0]});
            chk("gain amp on", {15'h0, i != 0}, {15'h0, amp_enable});
            chk("gain code", {13'h0, i[2:0]}, {13'h0, amp_factor_code});
        end
        wr(adcc_pkg::ADDR_CTRL, 8'ha8);
        chk("diff bypass", 16'h0000, {15'h0, amp_enable});
        wr(adcc_pkg::ADDR_CTRL, 8'hc0);
        chk("amp keeps path", 16'h1000, chan_plus_sel);
        wr(adcc_pkg::ADDR_GAIN, 8'h00);
    endtask

    task automatic t_gating;
        logic [7:0] cv[7] = '{8'ha0, 8'ha4, 8'hc4, 8'he4, 8'hf4, 8'h84, 8'h94};
        logic [15:0] pv[7] = '{16'h0000, 16'h0400, 16'h1000, 16'h0, 16'h0, 16'h0, 16'h0};
        for (int i = 0; i < 7; i++) begin
            wr(adcc_pkg::ADDR_CTRL, cv[i]);
            chk("plus gate", pv[i], chan_plus_sel);
            chk("route pin", {15'h0, cv[i][2]}, {15'h0, route_out_pin_en});
            chk("input pin", {15'h0, cv[i][2]}, {15'h0, conv_input_pin_en});
        end
        wr(adcc_pkg::ADDR_CTRL, 8'hac);
        chk("diff plus", 16'h0400, chan_plus_sel);
        chk("diff minus", 16'h0800, chan_minus_sel);
        wr(adcc_pkg::ADDR_CTRL, 8'h00);
    endtask

    // Temperature sensor path: single ended, mux output off, gain 1
    task automatic t_temp;
        wr(adcc_pkg::ADDR_GAIN, 8'h41);
        wr(adcc_pkg::ADDR_CTRL, 8'h70);
        repeat (4) @(posedge clk);
        chk("temp path", 16'h0080, chan_plus_sel);
        chk("temp enable", 16'h0001, {15'h0, temp_sense_en});
        wr(adcc_pkg::ADDR_GAIN, 8'h01);
        chk("temp sensor off", 16'h0000, chan_plus_sel);
        wr(adcc_pkg::ADDR_GAIN, 8'h00);
        wr(adcc_pkg::ADDR_CTRL, 8'h00);
    endtask

    task automatic t_conv(input logic div, input logic [9:0] v);
        vin = v;
        run({6'h28, div, 1'b1}, n, p);
        chk("done cycle", div ? 16'd209 : 16'd14, n[15:0]);
        chk("clock ticks", 16'd13, p[15:0]);
        rd(adcc_pkg::ADDR_CTRL, rdv);
        chk("busy cleared", 16'h0000, {15'h0, rdv[0]});
        rd(adcc_pkg::ADDR_RES_HIGH, rdv);
        chk("result high", {8'h00, v[9:2]}, {8'h00, rdv});
        rd(adcc_pkg::ADDR_RES_LOW, rdv);
        chk("result low", {8'h00, v[1:0], 6'h00}, {8'h00, rdv});
    endtask

    task automatic t_abort;
        vin = 10'h0f1;
        wr(adcc_pkg::ADDR_CTRL, 8'ha1);
        repeat (3) @(posedge clk);
        reg_wdata <= 8'ha0;
        reg_wr <= 1'b1;
        @(posedge clk);
        run(8'ha1, n, p);
        chk("restart cycle", 16'd14, n[15:0]);
        rd(adcc_pkg::ADDR_RES_HIGH, rdv);
        chk("restart result", 16'h003c, {8'h00, rdv});
        wr(adcc_pkg::ADDR_CTRL, 8'ha1);
        chk("sample window", 16'h0001, {15'h0, sample_en});
        wr(adcc_pkg::ADDR_CTRL, 8'ha0);
        vin = 10'h3ff;
        p = 0;
        repeat (40) begin
            @(posedge clk);
            #1 p += conv_done + conv_clk_en + sample_en;
        end
        chk("abort quiet", 16'h0000, p[15:0]);
        rd(adcc_pkg::ADDR_RES_HIGH, rdv);
        chk("result kept", 16'h003c, {8'h00, rdv});
    endtask

    task automatic t_sw_result;
        wr(adcc_pkg::ADDR_RES_HIGH, 8'h5a);
        wr(adcc_pkg::ADDR_RES_LOW, 8'hff);
        rd(adcc_pkg::ADDR_RES_HIGH, rdv);
        chk("sw result high", 16'h005a, {8'h00, rdv});
        rd(adcc_pkg::ADDR_RES_LOW, rdv);
        chk("sw result low", 16'h00c0, {8'h00, rdv});
    endtask

    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset_vals();
        t_gain();
        t_gating();
        t_temp();
        t_conv(1'b0, 10'h3ff);
        t_conv(1'b0, 10'h155);
        t_conv(1'b1, 10'h2aa);
        t_abort();
        t_sw_result();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("BAD watchdog expected finish seen hang");
        conclude();
    end
endmodule // adc_control_and_gain_select_tb_top
